// >>> bench/psq_adc_model.sv
// Purpose: converter and sense electrode model for the sequencer
// Assumes: one conversion per adc_start, done after lag+1 cycles
// Notes: data toggles between conversions so a stale code never passes
`timescale 1ns/1ps
`include "psq_defines.svh"
module psq_adc_model (
   input wire logic clk,
   input wire logic adc_start,
   input wire logic [`PSQ_CODE_W-1:0] afe_offset,
   input wire logic [`PSQ_CODE_W-1:0] c_total,
   input wire logic [3:0] lag,
   output logic adc_done,
   output logic [`PSQ_CODE_W-1:0] adc_data
);
   int cnt = 0;
   logic [`PSQ_CODE_W-1:0] val = 12'h000;
   initial begin
      adc_done = 1'b0;
      adc_data = 12'h000;
   end
   always @(posedge clk) begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (adc_start === 1'b1) begin
         // offset removed before conversion, floored at zero
         val <= (c_total > afe_offset) ? c_total - afe_offset : 12'h000;
         cnt <= int'(lag) + 1;
      end else if (cnt == 1) begin
         adc_done <= 1'b1;
         adc_data <= val;
         cnt <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule

// >>> bench/tb_proximity_sense_sequencer.sv
// Purpose: self-checking bench of the proximity sequencer
// Assumes: ce tied high, scan unit shortened to UNIT cycles
// Notes: expectations come from env, user and threshold picks
`timescale 1ns/1ps
`include "psq_defines.svh"
module tb_proximity_sense_sequencer;
   localparam int UNIT = 20;
   logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, touch_busy = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, junk;
   logic pready, pslverr, adc_claim, adc_start, adc_done, sel_s, sel_g, guard_en;
   logic boost, himm, near, pend, irq, last_err;
   logic req_d = 0, req_p = 0, req_s = 0;
   logic [3:0] gain, lag = 4'h1;
   logic [1:0] freq;
   logic [11:0] adc_data, afe_offset, raw_code, env = 12'h000, user = 12'h000;
   int err_total = 0, num_checks = 0, starts = 0;

   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      if (adc_start === 1'b1) starts <= starts + 1;
      if (adc_claim === 1'b1 && guard_en !== 1'b1) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, guard_en, 1'b1);
      end
   end

   psq_sequencer #(.UNIT_CYC(UNIT)) dut_u (.clk(clk), .rstn(rstn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .touch_busy(touch_busy), .adc_claim(adc_claim),
      .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
      .sense_electrode_select(sel_s), .guard_electrode_select(sel_g), .guard_drive_en(guard_en),
      .gain_setting(gain), .extra_gain_enable(boost), .excitation_frequency_select(freq),
      .noise_immunity_enable(himm), .afe_offset(afe_offset), .cal_req_drift(req_d),
      .cal_req_period(req_p), .cal_req_stuck(req_s), .raw_code(raw_code),
      .near_far_flag(near), .offset_cal_pending(pend), .irq(irq));
   psq_adc_model adc_u (.clk(clk), .adc_start(adc_start), .afe_offset(afe_offset),
      .c_total(env + user), .lag(lag), .adc_done(adc_done), .adc_data(adc_data));

   // ************************************************
   // bench tasks
   // ************************************************
   task automatic stop_test;
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // request held until the edge that samples pready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         stop_test();
      end
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, junk);
   endtask
   task automatic wait_pend(input logic v);
      int n;
      n = 0;
      while (pend !== v && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 3000) begin
         err_total++;
         stop_test();
      end
   endtask
   function automatic logic [31:0] exp_stat(input logic [11:0] u, input logic [11:0] th);
      return {15'h0, (u > th), 4'h0, u};
   endfunction

   // ************************************************
   // main sequence
   // ************************************************
   initial begin
      logic [31:0] r, v;
      logic [11:0] th;
      logic nf;
      int s;
      void'($urandom(61));
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b0, `PSQ_THRESH_OFS, 32'h0, r);
      chk(r, 32'h0000_0800);
      apb(1'b0, 8'h40, 32'h0, r);
      chk({r[30:0], last_err}, 32'h0000_0001);
      $display("test registers done");
      for (int i = 0; i < 6; i++) begin
         v = $urandom & 32'h0000_0f3f;
         if (!v[0]) v[2] = 1'b0;
         wr(`PSQ_CTRL_OFS, v);
         @(posedge clk);
         chk({20'h0, gain, 2'b00, freq, himm, boost, sel_g, sel_s}, v);
      end
      $display("test controls done");
      env <= 12'($urandom_range(12'h7ff, 12'h100));
      th = 12'($urandom_range(12'h7ff, 12'h001));
      lag <= 4'($urandom_range(9, 1));
      wr(`PSQ_THRESH_OFS, {20'h0, th});
      wr(`PSQ_IRQ_MASK_OFS, 32'h0);
      wr(`PSQ_SCAN_OFS, 32'h2);
      repeat (3) @(posedge clk);
      chk({31'h0, pend}, 32'h1);
      wait_pend(1'b0);
      apb(1'b0, `PSQ_OFFSET_OFS, 32'h0, r);
      chk(r, {20'h0, env});
      chk({20'h0, afe_offset}, {20'h0, env});
      nf = 1'b0;
      for (int k = 0; k < 3; k++) begin
         user <= (k == 0) ? th : 12'($urandom_range(12'h7ff, 0));
         lag <= 4'($urandom_range(9, 1));
         repeat (200) @(posedge clk);
         apb(1'b0, `PSQ_STATUS_OFS, 32'h0, r);
         chk(r & 32'h0001_0fff, exp_stat(user, th));
         chk({20'h0, raw_code}, {20'h0, user});
         chk({31'h0, near}, {31'h0, (user > th)});
         nf = nf | (user > th);
      end
      chk({31'h0, irq}, 32'h0);
      wr(`PSQ_IRQ_MASK_OFS, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      wr(`PSQ_SCAN_OFS, 32'h0);
      repeat (100) @(posedge clk);
      apb(1'b0, `PSQ_IRQ_STAT_OFS, 32'h0, r);
      chk(r, {29'h0, nf, 2'b11});
      wr(`PSQ_IRQ_STAT_OFS, 32'h7);
      apb(1'b0, `PSQ_IRQ_STAT_OFS, 32'h0, r);
      chk({r[30:0], irq}, 32'h0);
      $display("test measure done");
      s = starts;
      repeat (300) @(posedge clk);
      chk(32'(starts - s), 32'h0);
      for (int i = 0; i < 4; i++) begin
         if (i == 0) begin
            wr(`PSQ_CTRL_OFS, 32'h0001_0000);
         end else begin
            {req_d, req_p, req_s} <= 3'b100 >> (i - 1);
            @(posedge clk);
            {req_d, req_p, req_s} <= 3'b000;
         end
         repeat (4) @(posedge clk);
         chk({31'h0, pend}, 32'h1);
         wr(`PSQ_SCAN_OFS, 32'h2);
         wait_pend(1'b0);
         wr(`PSQ_SCAN_OFS, 32'h0);
         repeat (60) @(posedge clk);
         chk({31'h0, pend}, 32'h0);
      end
      $display("test sources done");
      touch_busy <= 1'b1;
      wr(`PSQ_SCAN_OFS, 32'h2);
      s = starts;
      repeat (150) @(posedge clk);
      chk({31'h0, adc_claim}, 32'h0);
      chk(32'(starts - s), 32'h0);
      touch_busy <= 1'b0;
      wait_pend(1'b0);
      repeat (10) @(posedge clk);
      chk({31'h0, (starts - s >= 2)}, 32'h1);
      $display("test sharing done");
      stop_test();
   end
endmodule

// >>> hdl/psq_cal_pending.sv
// Purpose: offset calibration pending flag with several request sources
// Assumes: clr is a one-cycle pulse at calibration completion
// Notes: a request in the clearing cycle keeps the flag set
`timescale 1ns/1ps
`include "psq_defines.svh"
module psq_cal_pending #(
   parameter int N_SRC = `PSQ_CAL_SRC_N
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [N_SRC-1:0] req,
   input wire logic clr,
   output logic pending
);
   typedef struct packed {
      logic pend;
   } psq_cal_st_t;
   psq_cal_st_t r_reg, r_next;

   generate
      if (N_SRC < 1) begin : g_bad
         $error("psq_cal_pending: N_SRC must be positive");
      end
   endgenerate

   always_comb begin
      r_next = r_reg;
      if (ce) begin
         // any source sets, only completion clears, set wins
         r_next.pend = (r_reg.pend & ~clr) | (|req);
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign pending = r_reg.pend;
endmodule

// >>> hdl/psq_defines.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 40 MHz clock, APB with byte addresses
// Notes: included by bare name
`ifndef PSQ_DEFINES_SVH
`define PSQ_DEFINES_SVH

// ******************************
// timing
// ******************************
`define PSQ_CLK_KHZ 40000
`define PSQ_SCAN_UNIT_US 1000
`define PSQ_SCAN_UNIT_CYC ((`PSQ_SCAN_UNIT_US * `PSQ_CLK_KHZ) / 1000)

// ******************************
// register offsets
// ******************************
`define PSQ_CTRL_OFS 8'h00
`define PSQ_SCAN_OFS 8'h04
`define PSQ_THRESH_OFS 8'h08
`define PSQ_STATUS_OFS 8'h0c
`define PSQ_IRQ_STAT_OFS 8'h10
`define PSQ_IRQ_MASK_OFS 8'h14
`define PSQ_OFFSET_OFS 8'h18

// ******************************
// fields
// ******************************
`define PSQ_CTRL_SENSE 0
`define PSQ_CTRL_GUARD 1
`define PSQ_CTRL_BOOST 2
`define PSQ_CTRL_HIMM 3
`define PSQ_CTRL_FREQ 4
`define PSQ_CTRL_GAIN 8
`define PSQ_CTRL_CALREQ 16
`define PSQ_STAT_NEAR 16
`define PSQ_STAT_PEND 17
`define PSQ_STAT_BUSY 18
`define PSQ_IRQ_DONE 0
`define PSQ_IRQ_CAL 1
`define PSQ_IRQ_NEAR 2
`define PSQ_IRQ_W 3
`define PSQ_CAL_SRC_N 5
`define PSQ_CODE_W 12
`define PSQ_SCAN_W 16

// ******************************
// reset values
// ******************************
`define PSQ_THRESH_RST 12'h800
`define PSQ_GAIN_RST 4'h0
`define PSQ_FREQ_RST 2'h0

`endif

// >>> hdl/psq_pkg.sv
// Purpose: shared types of the proximity sequencer
// Assumes: nothing
// Notes: constants live in psq_defines.svh
package psq_pkg;
   typedef enum logic [2:0] {
      PSQ_IDLE,
      PSQ_GRANT_WAIT,
      PSQ_START,
      PSQ_CONVERT,
      PSQ_UPDATE
   } psq_state_t;
endpackage

// >>> hdl/psq_scan_timer.sv
// Purpose: periodic wake pulse every scan_interval units
// Assumes: scan_interval of zero stops the timer
// Notes: restarts its count whenever the interval is zero
`timescale 1ns/1ps
`include "psq_defines.svh"
module psq_scan_timer #(
   parameter int UNIT_CYC = `PSQ_SCAN_UNIT_CYC,
   parameter int SCAN_W = `PSQ_SCAN_W
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [SCAN_W-1:0] scan_interval,
   output logic wake
);
   localparam int PW = (UNIT_CYC > 1) ? $clog2(UNIT_CYC) : 1;
   typedef struct packed {
      logic [PW-1:0] pre;
      logic [SCAN_W-1:0] cnt;
      logic wake;
   } psq_tmr_st_t;
   psq_tmr_st_t r_reg, r_next;

   generate
      if (UNIT_CYC < 1 || SCAN_W < 1) begin : g_bad
         $error("psq_scan_timer: bad parameters");
      end
   endgenerate

   always_comb begin
      r_next = r_reg;
      if (ce) begin
         r_next.wake = 1'b0;
         if (scan_interval == '0) begin
            // zero interval: no wake pulses, so no new scan starts; a conversion already under way still finishes
            r_next.pre = '0;
            r_next.cnt = '0;
         end else if (r_next.pre == PW'(UNIT_CYC - 1)) begin
            r_next.pre = '0;
            if (r_reg.cnt >= scan_interval - 1'b1) begin
               // one wake per programmed period
               r_next.cnt = '0;
               r_next.wake = 1'b1;
            end else begin
               r_next.cnt = r_reg.cnt + 1'b1;
            end
         end else begin
            r_next.pre = r_reg.pre + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign wake = r_reg.wake;
endmodule

// >>> hdl/psq_sequencer.sv
// Purpose: proximity sense sequencer with APB registers
// Assumes: shared converter arbitrated by touch_busy and adc_claim
// Notes: filtering chain is outside; near flag is a plain compare
`timescale 1ns/1ps
`include "psq_defines.svh"
module psq_sequencer #(
   parameter int ADDR_W = 8,
   parameter int SCAN_W = `PSQ_SCAN_W,
   parameter int UNIT_CYC = `PSQ_SCAN_UNIT_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic touch_busy,
   output logic adc_claim,
   output logic adc_start,
   input wire logic adc_done,
   input wire logic [`PSQ_CODE_W-1:0] adc_data,
   output logic sense_electrode_select,
   output logic guard_electrode_select,
   output logic guard_drive_en,
   output logic [3:0] gain_setting,
   output logic extra_gain_enable,
   output logic [1:0] excitation_frequency_select,
   output logic noise_immunity_enable,
   output logic [`PSQ_CODE_W-1:0] afe_offset,
   input wire logic cal_req_drift,
   input wire logic cal_req_period,
   input wire logic cal_req_stuck,
   output logic [`PSQ_CODE_W-1:0] raw_code,
   output logic near_far_flag,
   output logic offset_cal_pending,
   output logic irq
);
   localparam int CW = `PSQ_CODE_W;
   localparam int IW = `PSQ_IRQ_W;

   typedef struct packed {
      psq_pkg::psq_state_t state;
      logic cal_phase;
      logic sense;
      logic guard;
      logic boost;
      logic himm;
      logic [1:0] freq;
      logic [3:0] gain;
      logic [SCAN_W-1:0] scan;
      logic [CW-1:0] thresh;
      logic [CW-1:0] raw;
      logic [CW-1:0] offset;
      logic near;
      logic [IW-1:0] irq_stat;
      logic [IW-1:0] irq_mask;
      logic [31:0] prdata;
      logic rd_ok;
      logic cal_host;
      logic cal_boot;
      logic cal_clr;
   } psq_main_st_t;

   psq_main_st_t r_reg, r_next;
   logic wake;
   logic acc;

   generate
      if (ADDR_W < 8 || SCAN_W < 1 || SCAN_W > 32) begin : g_bad
         $error("psq_sequencer: bad parameters");
      end
   endgenerate

   // ******************************
   // helpers
   // ******************************
   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      // upper bits must be zero; a shift keeps an 8-bit address legal
      case (a[7:0])
         `PSQ_CTRL_OFS, `PSQ_SCAN_OFS, `PSQ_THRESH_OFS, `PSQ_STATUS_OFS,
         `PSQ_IRQ_STAT_OFS, `PSQ_IRQ_MASK_OFS, `PSQ_OFFSET_OFS: addr_ok = ((a >> 8) == '0);
         default: addr_ok = 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a, input psq_main_st_t s,
                                           input logic pend);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (addr_ok(a)) begin
         case (a[7:0])
            `PSQ_CTRL_OFS: begin
               w[`PSQ_CTRL_SENSE] = s.sense;
               w[`PSQ_CTRL_GUARD] = s.guard;
               w[`PSQ_CTRL_BOOST] = s.boost;
               w[`PSQ_CTRL_HIMM] = s.himm;
               w[`PSQ_CTRL_FREQ +: 2] = s.freq;
               w[`PSQ_CTRL_GAIN +: 4] = s.gain;
            end
            `PSQ_SCAN_OFS: w[SCAN_W-1:0] = s.scan;
            `PSQ_THRESH_OFS: w[CW-1:0] = s.thresh;
            `PSQ_STATUS_OFS: begin
               w[CW-1:0] = s.raw;
               w[`PSQ_STAT_NEAR] = s.near;
               w[`PSQ_STAT_PEND] = pend;
               w[`PSQ_STAT_BUSY] = (s.state != psq_pkg::PSQ_IDLE);
            end
            `PSQ_IRQ_STAT_OFS: w[IW-1:0] = s.irq_stat;
            `PSQ_IRQ_MASK_OFS: w[IW-1:0] = s.irq_mask;
            `PSQ_OFFSET_OFS: w[CW-1:0] = s.offset;
            default: w = 32'h0000_0000;
         endcase
      end
      rd_word = w;
   endfunction

   // ******************************
   // submodules
   // ******************************
   psq_scan_timer #(.UNIT_CYC(UNIT_CYC), .SCAN_W(SCAN_W)) u_timer (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .scan_interval(r_reg.scan),
      .wake(wake)
   );

   // sources: host, start-up, drift, periodic, stuck
   psq_cal_pending #(.N_SRC(`PSQ_CAL_SRC_N)) u_cal (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .req({cal_req_stuck, cal_req_period, cal_req_drift, r_reg.cal_boot, r_reg.cal_host}),
      .clr(r_reg.cal_clr),
      .pending(offset_cal_pending)
   );

   // ******************************
   // bus and sequencer
   // ******************************
   // read data is sampled in the setup cycle so it comes from a flop;
   // costs no wait state but reflects state one cycle early
   assign pready = psel & penable & r_reg.rd_ok & ce;
   assign acc = pready;
   assign pslverr = acc & ~addr_ok(paddr);

   always_comb begin
      logic [IW-1:0] ev;
      logic [IW-1:0] clr;
      ev = '0;
      clr = '0;
      r_next = r_reg;
      if (ce) begin
         // pulses drop only on an enabled cycle, so a frozen cycle loses none
         r_next.cal_host = 1'b0;
         r_next.cal_boot = 1'b0;
         r_next.cal_clr = 1'b0;
         if (psel && !r_reg.rd_ok) begin
            r_next.prdata = rd_word(paddr, r_reg, offset_cal_pending);
            r_next.rd_ok = 1'b1;
         end else if (acc) begin
            r_next.rd_ok = 1'b0;
         end
         if (!psel) begin
            r_next.rd_ok = 1'b0;
         end
         if (acc && pwrite && addr_ok(paddr)) begin
            case (paddr[7:0])
               `PSQ_CTRL_OFS: begin
                  r_next.sense = pwdata[`PSQ_CTRL_SENSE];
                  r_next.guard = pwdata[`PSQ_CTRL_GUARD];
                  r_next.boost = pwdata[`PSQ_CTRL_BOOST];
                  r_next.himm = pwdata[`PSQ_CTRL_HIMM];
                  r_next.freq = pwdata[`PSQ_CTRL_FREQ +: 2];
                  r_next.gain = pwdata[`PSQ_CTRL_GAIN +: 4];
                  r_next.cal_host = pwdata[`PSQ_CTRL_CALREQ];
               end
               `PSQ_SCAN_OFS: begin
                  r_next.scan = pwdata[SCAN_W-1:0];
                  // turning scanning on asks for a calibration
                  r_next.cal_boot = (r_reg.scan == '0) && (pwdata[SCAN_W-1:0] != '0);
               end
               `PSQ_THRESH_OFS: r_next.thresh = pwdata[CW-1:0];
               `PSQ_IRQ_STAT_OFS: clr = pwdata[IW-1:0];
               `PSQ_IRQ_MASK_OFS: r_next.irq_mask = pwdata[IW-1:0];
               default: ;
            endcase
         end
         case (r_reg.state)
            psq_pkg::PSQ_IDLE: begin
               // the sequencer alone launches front-end work
               if (wake && r_reg.scan != '0) begin
                  r_next.cal_phase = offset_cal_pending;
                  r_next.state = psq_pkg::PSQ_GRANT_WAIT;
               end
            end
            psq_pkg::PSQ_GRANT_WAIT: begin
               if (r_reg.scan == '0) begin
                  r_next.state = psq_pkg::PSQ_IDLE;
               end else if (!touch_busy) begin
                  // only take the converter once touch has let go
                  r_next.state = psq_pkg::PSQ_START;
                  if (r_reg.cal_phase) begin
                     r_next.offset = '0; // measure environment unbiased
                  end
               end
            end
            psq_pkg::PSQ_START: r_next.state = psq_pkg::PSQ_CONVERT;
            psq_pkg::PSQ_CONVERT: begin
               if (adc_done) begin
                  if (r_reg.cal_phase) begin
                     // keep the environment value, then measure
                     r_next.offset = adc_data;
                     r_next.cal_phase = 1'b0;
                     r_next.cal_clr = 1'b1;
                     ev[`PSQ_IRQ_CAL] = 1'b1;
                     r_next.state = psq_pkg::PSQ_START;
                  end else begin
                     r_next.raw = adc_data;
                     r_next.state = psq_pkg::PSQ_UPDATE;
                  end
               end
            end
            psq_pkg::PSQ_UPDATE: begin
               r_next.near = (r_reg.raw > r_reg.thresh);
               ev[`PSQ_IRQ_NEAR] = r_next.near ^ r_reg.near;
               ev[`PSQ_IRQ_DONE] = 1'b1;
               r_next.state = psq_pkg::PSQ_IDLE;
            end
            default: r_next.state = psq_pkg::PSQ_IDLE;
         endcase
         // events win over a simultaneous clear
         r_next.irq_stat = (r_reg.irq_stat & ~clr) | ev;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         r_reg <= '0;
         r_reg.state <= psq_pkg::PSQ_IDLE;
         r_reg.thresh <= `PSQ_THRESH_RST;
         r_reg.gain <= `PSQ_GAIN_RST;
         r_reg.freq <= `PSQ_FREQ_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // ******************************
   // outputs
   // ******************************
   assign prdata = r_reg.prdata;
   assign adc_claim = (r_reg.state == psq_pkg::PSQ_START) || (r_reg.state == psq_pkg::PSQ_CONVERT)
                      || (r_reg.state == psq_pkg::PSQ_UPDATE);
   assign adc_start = (r_reg.state == psq_pkg::PSQ_START);
   assign sense_electrode_select = r_reg.sense;
   assign guard_electrode_select = r_reg.guard;
   assign guard_drive_en = adc_claim;
   assign gain_setting = r_reg.gain;
   assign extra_gain_enable = r_reg.boost;
   assign excitation_frequency_select = r_reg.freq;
   assign noise_immunity_enable = r_reg.himm;
   assign afe_offset = r_reg.offset;
   assign raw_code = r_reg.raw;
   assign near_far_flag = r_reg.near;
   assign irq = |(r_reg.irq_stat & r_reg.irq_mask);

   // ******************************
   // assertions
   // ******************************
   logic scan_on_wr;
   assign scan_on_wr = acc && pwrite && (paddr[7:0] == `PSQ_SCAN_OFS) && addr_ok(paddr)
                       && (r_reg.scan == '0) && (pwdata[SCAN_W-1:0] != '0);

   a_busy_no_start: assert property (@(posedge clk) disable iff (!rstn)
      (r_reg.state == psq_pkg::PSQ_GRANT_WAIT && touch_busy) |=> !adc_start)
      else $error("converter started while touch busy");
   a_conv_exclusive: assert property (@(posedge clk) disable iff (!rstn)
      $rose(adc_claim) |-> $past(!touch_busy))
      else $error("converter claimed while touch held it");
   a_start_single: assert property (@(posedge clk) disable iff (!rstn)
      (adc_start && ce) |=> !adc_start ##0 (r_reg.state == psq_pkg::PSQ_CONVERT))
      else $error("start pulse not single");
   a_guard_driven: assert property (@(posedge clk) disable iff (!rstn)
      adc_start |-> guard_drive_en ##1 guard_drive_en)
      else $error("shield not driven during conversion");
   a_zero_idle: assert property (@(posedge clk) disable iff (!rstn)
      (r_reg.scan == '0 && r_reg.state == psq_pkg::PSQ_IDLE) |=> !adc_claim)
      else $error("activity with zero interval");
   a_cal_first: assert property (@(posedge clk) disable iff (!rstn)
      (ce && wake && r_reg.state == psq_pkg::PSQ_IDLE && r_reg.scan != '0 && offset_cal_pending)
      |=> r_reg.cal_phase)
      else $error("pending calibration skipped");
   a_pend_hold: assert property (@(posedge clk) disable iff (!rstn)
      (offset_cal_pending && !r_reg.cal_clr) |=> offset_cal_pending)
      else $error("pending flag dropped early");
   a_startup_req: assert property (@(posedge clk) disable iff (!rstn)
      scan_on_wr |=> ##1 offset_cal_pending)
      else $error("enabling did not request calibration");
   a_offset_store: assert property (@(posedge clk) disable iff (!rstn)
      (ce && r_reg.state == psq_pkg::PSQ_CONVERT && adc_done && r_reg.cal_phase)
      |=> afe_offset == $past(adc_data))
      else $error("environment offset not stored");
   a_raw_capture: assert property (@(posedge clk) disable iff (!rstn)
      (ce && r_reg.state == psq_pkg::PSQ_CONVERT && adc_done && !r_reg.cal_phase)
      |=> raw_code == $past(adc_data))
      else $error("raw code not captured");
   a_near_update: assert property (@(posedge clk) disable iff (!rstn)
      (ce && r_reg.state == psq_pkg::PSQ_UPDATE) |=> near_far_flag == (raw_code > r_reg.thresh))
      else $error("near flag wrong");

   c_cal_then_meas: cover property (@(posedge clk) disable iff (!rstn)
      r_reg.cal_clr ##[1:100] (r_reg.state == psq_pkg::PSQ_UPDATE));
   c_touch_wait: cover property (@(posedge clk) disable iff (!rstn)
      (r_reg.state == psq_pkg::PSQ_GRANT_WAIT && touch_busy) ##1 adc_start);
   c_near_rise: cover property (@(posedge clk) disable iff (!rstn) $rose(near_far_flag));
endmodule
